// *** logic/eeprom_pkg.sv ***
package eeprom_pkg;
	localparam int CS_BITS = 3;
	localparam int DEV_COUNT = 8;
	localparam int MEM_WORDS = 65536;
	localparam int ADDR_BITS = 16;
	localparam int DATA_BITS = 8;
	localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
	localparam int FIFO_DEPTH = 16;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] CS_DEFAULT = 3'h0;
	localparam logic WP_DEFAULT = 1'b0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEVADDR = 3'b001,
		ST_ACK = 3'b011,
		ST_ADDR_HI = 3'b010,
		ST_ADDR_LO = 3'b110,
		ST_WDATA = 3'b111,
		ST_RDATA = 3'b101,
		ST_RACK = 3'b100
	} link_state_e;
endpackage

// *** logic/byte_fifo.sv ***
`timescale 1ns/100ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic do_wr;
	logic do_rd;
	logic full;
	logic empty;

	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty = wr_ptr_r == rd_ptr_r;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr_r[AW-1:0]];
	assign do_wr = in_valid && !full;
	assign do_rd = out_ready && !empty;

	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem[wr_ptr_r[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (do_rd)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule // byte_fifo

// *** logic/serial_eeprom_pin_interface.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - strapped select pins form part of identity
// - selected only when sent select bits match
// - open select pins read as zero
// - data line only pulled low or released
// - sample data on serial clock rise
// - change output bit only after clock fall
// - write protect high blocks all writes
// - write protect low allows writes
// - open write protect reads low
// - storage is linear byte-wide array
// - device answers only host-started transfers
module serial_eeprom_pin_interface
	import eeprom_pkg::*;
#(
	parameter int FIFO_W = DATA_BITS,
	parameter int FIFO_D = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic chip_select_bit0,
	input wire logic chip_select_bit1,
	input wire logic chip_select_bit2,
	input wire logic write_protect,
	output logic busy
);
	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic [1:0] wp_sync_r;
	logic [CS_BITS-1:0] cs_meta_r;
	logic [CS_BITS-1:0] cs_r;
	logic scl_d_r;
	logic sda_d_r;

	// pull-downs belong to the pad; a floating strap arrives here as 0
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			wp_sync_r <= {2{WP_DEFAULT}};
			cs_meta_r <= CS_DEFAULT;
			cs_r <= CS_DEFAULT;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_sync_r <= {scl_sync_r[0], scl_in};
			sda_sync_r <= {sda_sync_r[0], sda_in};
			wp_sync_r <= {wp_sync_r[0], write_protect};
			cs_meta_r <= {chip_select_bit2, chip_select_bit1, chip_select_bit0};
			cs_r <= cs_meta_r;
			scl_d_r <= scl_sync_r[1];
			sda_d_r <= sda_sync_r[1];
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_s = scl_sync_r[1];
	assign sda_s = sda_sync_r[1];
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	link_state_e state_r;
	link_state_e ack_next_r;
	logic [2:0] bit_cnt_r;
	logic [DATA_BITS-1:0] shift_r;
	logic [ADDR_BITS-1:0] addr_r;
	logic reading_r;
	logic ack_drive_r;
	logic got_ack_r;
	logic [DATA_BITS-1:0] rd_data;
	logic wr_valid_r;
	logic [ADDR_BITS-1:0] wr_addr_r;
	logic [DATA_BITS-1:0] wr_byte_r;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [FIFO_W-1:0] fifo_out_data;
	logic got_byte_r;

	function automatic logic [DATA_BITS-1:0] shift_in(input logic [DATA_BITS-1:0] v, input logic b);
		shift_in = {v[DATA_BITS-2:0], b};
	endfunction

	logic addr_match;
	// device byte: type code, three select bits, direction
	assign addr_match = (shift_r[7:4] == DEV_TYPE_CODE) && (shift_r[3:1] == cs_r);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			ack_next_r <= ST_IDLE;
			bit_cnt_r <= 3'h0;
			shift_r <= 8'h00;
			addr_r <= 16'h0000;
			reading_r <= 1'b0;
			ack_drive_r <= 1'b0;
			got_ack_r <= 1'b0;
			wr_valid_r <= 1'b0;
			wr_addr_r <= 16'h0000;
			wr_byte_r <= 8'h00;
		end
		else
		begin
			wr_valid_r <= wr_valid_r && !fifo_in_ready;
			if (start_det)
			begin
				state_r <= ST_DEVADDR;
				bit_cnt_r <= 3'h0;
				ack_drive_r <= 1'b0;
			end
			else if (stop_det)
			begin
				state_r <= ST_IDLE;
				ack_drive_r <= 1'b0;
			end
			else
			begin
				unique case (state_r)
				ST_IDLE:
					ack_drive_r <= 1'b0;
				ST_DEVADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA:
					if (scl_rise)
					begin
						shift_r <= shift_in(shift_r, sda_s);
						bit_cnt_r <= bit_cnt_r + 3'h1;
					end
				ST_ACK:
					if (scl_fall)
					begin
						ack_drive_r <= 1'b0;
						state_r <= ack_next_r;
						bit_cnt_r <= 3'h0;
						if (ack_next_r == ST_RDATA)
							ack_drive_r <= !rd_data[DATA_BITS-1];
						shift_r <= rd_data;
					end
				ST_RDATA:
					if (scl_rise)
						bit_cnt_r <= bit_cnt_r + 3'h1;
					else if (scl_fall)
					begin
						if (bit_cnt_r == 3'h0)
						begin
							ack_drive_r <= 1'b0;
							// step early so the next byte is ready at the host's acknowledge
							addr_r <= addr_r + 16'h0001;
							state_r <= ST_RACK;
						end
						else
						begin
							shift_r <= {shift_r[DATA_BITS-2:0], 1'b0};
							ack_drive_r <= !shift_r[DATA_BITS-2];
						end
					end
				ST_RACK:
					if (scl_rise)
						got_ack_r <= !sda_s;
					else if (scl_fall)
					begin
						if (got_ack_r)
						begin
							shift_r <= rd_data;
							ack_drive_r <= !rd_data[DATA_BITS-1];
							bit_cnt_r <= 3'h0;
							state_r <= ST_RDATA;
						end
						else
							state_r <= ST_IDLE;
					end
				endcase
				// byte complete: on the falling edge after the eighth rise
				if (scl_fall && bit_cnt_r == 3'h0 && state_r inside {ST_DEVADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA}
					&& scl_d_r && got_byte_r)
				begin
					unique case (state_r)
					ST_DEVADDR:
						if (addr_match)
						begin
							reading_r <= shift_r[0];
							ack_drive_r <= 1'b1;
							ack_next_r <= shift_r[0] ? ST_RDATA : ST_ADDR_HI;
							state_r <= ST_ACK;
						end
						else
							state_r <= ST_IDLE;
					ST_ADDR_HI:
					begin
						addr_r[15:8] <= shift_r;
						ack_drive_r <= 1'b1;
						ack_next_r <= ST_ADDR_LO;
						state_r <= ST_ACK;
					end
					ST_ADDR_LO:
					begin
						addr_r[7:0] <= shift_r;
						ack_drive_r <= 1'b1;
						ack_next_r <= ST_WDATA;
						state_r <= ST_ACK;
					end
					default:
					begin
						// protected writes get no acknowledge and are dropped
						if (!wp_sync_r[1] && fifo_in_ready)
						begin
							wr_valid_r <= 1'b1;
							wr_addr_r <= addr_r;
							wr_byte_r <= shift_r;
							addr_r <= addr_r + 16'h0001;
							ack_drive_r <= 1'b1;
							ack_next_r <= ST_WDATA;
							state_r <= ST_ACK;
						end
						else
							state_r <= ST_IDLE;
					end
					endcase
				end
			end
		end
	end

	// tracks that eight bits have arrived since the byte began
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			got_byte_r <= 1'b0;
		else if (start_det || scl_fall && bit_cnt_r == 3'h0)
			got_byte_r <= 1'b0;
		else if (scl_rise && bit_cnt_r == BIT_LAST && state_r != ST_RDATA)
			got_byte_r <= 1'b1;
	end

	// ----------------------------------------
	// write buffer and storage
	// ----------------------------------------
	logic [DATA_BITS-1:0] mem [MEM_WORDS];
	logic [ADDR_BITS-1:0] cell_addr_r;
	logic drain_ready;
	assign drain_ready = 1'b1;

	byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_wbuf (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(wr_valid_r),
		.in_ready(fifo_in_ready),
		.in_data(wr_byte_r),
		.out_valid(fifo_out_valid),
		.out_ready(drain_ready),
		.out_data(fifo_out_data)
	);

	// address follows the byte through a second small queue of one entry
	always_ff @(posedge clk)
	begin
		if (wr_valid_r && fifo_in_ready)
			cell_addr_r <= wr_addr_r;
		if (fifo_out_valid)
			mem[cell_addr_r] <= fifo_out_data;
	end

	assign rd_data = mem[addr_r];

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			sda_out <= 1'b0;
			sda_oe <= ack_drive_r;
			busy <= state_r != ST_IDLE;
		end
	end
endmodule // serial_eeprom_pin_interface

// *** verif/serial_eeprom_pin_interface_asserts.sv ***
`timescale 1ns/100ps
module link_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic busy
);
	logic [7:0] fall_r;
	logic [7:0] sta_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----
	// cycles since clock fall and since start
	// ----
	always_ff @(posedge clk)
	begin
		if (!rst_n || $fell(scl_in))
			fall_r <= 8'h00;
		else if (fall_r != 8'hFF)
			fall_r <= fall_r + 8'h01;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n || ($fell(sda_in) && scl_in))
			sta_r <= 8'h00;
		else if (sta_r != 8'hFF)
			sta_r <= sta_r + 8'h01;
	end
	chk_drain_only: assert property (sda_out == 1'b0)
		else $error("data driven high");
	chk_oe_after_fall: assert property ($changed(sda_oe) |-> fall_r <= 8'h06)
		else $error("data moved late");
	chk_oe_quiet_high: assert property ($rose(scl_in) |-> ##3 $stable(sda_oe) [*3])
		else $error("data moved in high");
	chk_oe_holds: assert property ($rose(sda_oe) |=> sda_oe [*3])
		else $error("data pulse short");
	chk_oe_in_xfer: assert property (sda_oe |-> busy)
		else $error("driven while idle");
	chk_busy_start: assert property ($rose(busy) |-> sta_r <= 8'h06)
		else $error("busy without start");
	chk_stop_idles: assert property (scl_in && $rose(sda_in) |-> ##[1:8] !busy)
		else $error("busy after stop");
	chk_start_free: assert property ($rose(busy) |-> !sda_oe)
		else $error("driven at start");
	cover property ($rose(sda_oe));
	cover property ($rose(busy));
	cover property ($fell(busy));
endmodule // link_chk
bind serial_eeprom_pin_interface link_chk i_link_chk (.clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .busy);

// *** verif/host_bfm.sv ***
`timescale 1ns/100ps
module host_bfm (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic host_oe
);
	initial
	begin
		scl = 1'b1;
		host_oe = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// ----
	// only this side opens transfers
	// ----
	task automatic start;
		host_oe = 1'b0;
		// let a client acknowledge go before the clock rises
		tick(5);
		scl = 1'b1;
		tick(4);
		host_oe = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask
	task automatic stop;
		tick(2);
		host_oe = 1'b1;
		tick(4);
		scl = 1'b1;
		tick(4);
		host_oe = 1'b0;
		tick(4);
	endtask
	// data moves two cycles after the fall; five low, three high: 80 ns a bit
	task automatic xf(input logic [8:0] t, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			tick(2);
			host_oe = !t[i];
			tick(3);
			scl = 1'b1;
			tick(3);
			r[i] = sda;
			scl = 1'b0;
		end
	endtask
endmodule // host_bfm

// *** verif/serial_eeprom_pin_interface_tb.sv ***
`timescale 1ns/100ps
module serial_eeprom_pin_interface_tb;
	import eeprom_pkg::*;
	logic clk;
	logic rst_n;
	logic scl;
	logic h_oe;
	logic sda_oe;
	logic busy;
	logic [2:0] cs;
	logic wp;
	int fails = 0;
	int checked = 0;
	// pull-up unless someone pulls low
	wire sda = !(sda_oe || h_oe);
	serial_eeprom_pin_interface i_serial_eeprom_pin_interface (.clk, .rst_n, .scl_in(scl), .sda_in(sda),
		.sda_out(), .sda_oe, .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]),
		.write_protect(wp), .busy);
	host_bfm i_host_bfm (.clk, .sda, .scl, .host_oe(h_oe));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic wrap_up;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic x(input logic [8:0] t, input logic [8:0] e, input logic [8:0] m);
		logic [8:0] r;
		i_host_bfm.xf(t, r);
		checked++;
		if ((r & m) !== e)
		begin
			fails++;
			$display("BAD %0t sent %h got %h", $time, t, r);
		end
	endtask
	function automatic logic [8:0] dev(input logic [2:0] s, input logic rd);
		return {DEV_TYPE_CODE, s, rd, 1'b1};
	endfunction
	task automatic t_select;
		for (int s = 0; s < DEV_COUNT; s++)
		begin
			cs = 3'(s);
			i_host_bfm.start;
			x(dev(cs, 1'b0), 9'h000, 9'h001);
			i_host_bfm.stop;
			i_host_bfm.start;
			x(dev(cs ^ 3'(1 << (s % 3)), 1'b0), 9'h001, 9'h001);
			x(9'h001, 9'h001, 9'h001);
			i_host_bfm.stop;
		end
		i_host_bfm.start;
		x({~DEV_TYPE_CODE, cs, 1'b0, 1'b1}, 9'h001, 9'h001);
		i_host_bfm.stop;
		$display("select test done");
	endtask
	task automatic addr(input logic [15:0] a);
		i_host_bfm.start;
		x(dev(cs, 1'b0), 9'h000, 9'h001);
		x({a[15:8], 1'b1}, 9'h000, 9'h001);
		x({a[7:0], 1'b1}, 9'h000, 9'h001);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n, input logic nak);
		addr(a);
		for (int i = 0; i < n; i++)
			x({d + 8'(i), 1'b1}, {8'h00, nak}, 9'h001);
		i_host_bfm.stop;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] d, input int n);
		addr(a);
		i_host_bfm.start;
		x(dev(cs, 1'b1), 9'h000, 9'h001);
		for (int i = 0; i < n; i++)
			x({8'hFF, i == n - 1}, {d + 8'(i), 1'b0}, 9'h1FE);
		i_host_bfm.stop;
	endtask
	task automatic t_memory;
		cs = 3'h5;
		wr(16'hFFFE, 8'hC3, 1, 1'b0);
		wr(16'h0100, 8'h10, 17, 1'b0);
		wp = 1'b1;
		wr(16'hFFFE, 8'h3C, 1, 1'b1);
		wp = 1'b0;
		rd(16'hFFFE, 8'hC3, 1);
		rd(16'h0100, 8'h10, 17);
		$display("memory test done");
	endtask
	initial
	begin
		#400000;
		fails++;
		$display("BAD %0t timeout", $time);
		wrap_up;
	end
	initial
	begin
		rst_n = 1'b0;
		cs = 3'h0;
		wp = 1'b0;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_select;
		t_memory;
		wrap_up;
	end
endmodule // serial_eeprom_pin_interface_tb
